// *** verilog/hpc_cfg.svh ***
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets, byte addresses on the Wishbone bus.
// ----------------------------------------------------------------------------
`define HPC_OFS_A_OUT 8'h00
`define HPC_OFS_B_OUT 8'h04
`define HPC_OFS_CTRL 8'h08
`define HPC_OFS_A_IN 8'h0c
`define HPC_OFS_B_IN 8'h10
`define HPC_OFS_STAT 8'h14

// ----------------------------------------------------------------------------
// Output word fields.
// ----------------------------------------------------------------------------
`define HPC_OW_FUNC 0
`define HPC_OW_CONN 1
`define HPC_OW_DSIG 2
`define HPC_OW_PAR 3
`define HPC_OW_DLO 4

// ----------------------------------------------------------------------------
// Input word fields.
// ----------------------------------------------------------------------------
`define HPC_IW_EOR 0
`define HPC_IW_REJ 1
`define HPC_IW_REPLY 2
`define HPC_IW_PAR 3
`define HPC_IW_DLO 4

// ----------------------------------------------------------------------------
// Shared control word fields, interface A at the base, B one above.
// ----------------------------------------------------------------------------
`define HPC_CW_SEL 0
`define HPC_CW_NBCD 2
`define HPC_CW_TEST 4
`define HPC_CW_WMARK 6
`define HPC_CW_NOASM 8
`define HPC_CW_MCLR 10
`define HPC_CW_WRITE 12
`define HPC_CW_READ 14

// ----------------------------------------------------------------------------
// Shared status word fields, interface A at the base, B one above.
// ----------------------------------------------------------------------------
`define HPC_SW_RESP 0
`define HPC_SW_PERR 2
`define HPC_SW_INT 4

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define HPC_RST_WORD 16'h0000
`define HPC_RST_CODE 12'h000

`endif

// *** verilog/hpc_pkg.sv ***
package hpc_pkg;

  typedef logic [11:0] hpc_byte_t;
  typedef logic [15:0] hpc_word_t;

  typedef enum logic [1:0] {
    HPC_IDLE,
    HPC_WAIT_DATA,
    HPC_ANSWERED
  } hpc_pstate_e;

endpackage

// *** verilog/hpc_link_if.sv ***
`timescale 1ns/1ps

interface hpc_link_if;
  hpc_pkg::hpc_byte_t out_code;
  logic out_par;
  logic conn;
  logic func;
  logic dsig;
  logic wr;
  logic rd;
  logic wmark;
  logic nbcd;
  logic noasm;
  logic mclr;
  hpc_pkg::hpc_byte_t in_data;
  logic in_par;
  hpc_pkg::hpc_byte_t status;
  logic reply;
  logic reject;
  logic eor;
  logic par_err;
  logic intr;

  modport host (
    output out_code, out_par, conn, func, dsig, wr, rd, wmark, nbcd, noasm, mclr,
    input in_data, in_par, status, reply, reject, eor, par_err, intr
  );

  modport periph (
    input out_code, out_par, conn, func, dsig, wr, rd, wmark, nbcd, noasm, mclr,
    output in_data, in_par, status, reply, reject, eor, par_err, intr
  );
endinterface

// *** verilog/hpc_host.sv ***
// Overview of operation
// - Input word shows status when selected, else data.
// - Response flag on reply, reject or end-of-record.
// - Output parity error sticky until master clear.
// - Interrupt flag follows any controller interrupt.
// - Connect first; unconnected controller ignores commands.
// - Connect: code, odd parity, connect bit, await reply.
// - No connect reply means no controller.
// - Connect held shows controller status word.
// - Function: code, parity, function bit, await response.
// - No function response means code not accepted.
// - Write: hold write, handshake each byte.
// - Reply drops after data signal clears.
// - Read: data signal, await response, check end.
// - Input parity passed unchecked to software.
// - Connected controller always offers status word.
// - Issue functions and check status before data.
// - Last input byte flags end-of-record instead.
// - Master clear disconnects and clears function setup; here func_code keeps its last value.
// - Interface B mirrors interface A independently.
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "hpc_cfg.svh"

// ----------------------------------------------------------------------------
// One channel of the host port.
// ----------------------------------------------------------------------------
module hpc_host_chan (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Software words
  input wire hpc_pkg::hpc_word_t out_word,
  input wire logic sel_status,
  input wire logic nbcd,
  input wire logic test,
  input wire logic wmark,
  input wire logic noasm,
  input wire logic mclr,
  input wire logic wr,
  input wire logic rd,
  output hpc_pkg::hpc_word_t in_word,
  output logic resp,
  output logic perr,
  output logic intr,
  // Link
  hpc_link_if.host link
);

  logic test_reply;

  // --------------------------------------------------------------------------
  // Link outputs, registered copies of the software words, with connect, function and data signal forced low in test mode.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.out_code <= `HPC_RST_CODE;
      link.out_par <= 1'b0;
      link.conn <= 1'b0;
      link.func <= 1'b0;
      link.dsig <= 1'b0;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.wmark <= 1'b0;
      link.nbcd <= 1'b0;
      link.noasm <= 1'b0;
      link.mclr <= 1'b0;
    end else begin
      link.out_code <= out_word[15:`HPC_OW_DLO];
      link.out_par <= out_word[`HPC_OW_PAR];
      link.conn <= out_word[`HPC_OW_CONN] & ~test;
      link.func <= out_word[`HPC_OW_FUNC] & ~test;
      link.dsig <= out_word[`HPC_OW_DSIG] & ~test;
      link.wr <= wr;
      link.rd <= rd;
      link.wmark <= wmark;
      link.nbcd <= nbcd;
      link.noasm <= noasm;
      link.mclr <= mclr;
    end
  end

  assign test_reply = |out_word[`HPC_OW_DSIG:`HPC_OW_FUNC];

  // --------------------------------------------------------------------------
  // Input word.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_word <= `HPC_RST_WORD;
    end else if (test) begin
      in_word <= {out_word[15:`HPC_OW_DLO], out_word[`HPC_OW_PAR], test_reply, 2'b00};
    end else if (sel_status || link.conn || link.func) begin
      in_word <= {link.status, 1'b0, link.reply, link.reject, link.eor};
    end else begin
      in_word <= {link.in_data, link.in_par, link.reply, link.reject, link.eor};
    end
  end

  // --------------------------------------------------------------------------
  // Shared status bits of this channel.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp <= 1'b0;
    end else begin
      resp <= test ? test_reply : (link.reply | link.reject | link.eor);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      perr <= 1'b0;
    end else if (link.par_err) begin
      perr <= 1'b1;
    end else if (mclr) begin
      perr <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intr <= 1'b0;
    end else begin
      intr <= link.intr;
    end
  end

endmodule // hpc_host_chan

// ----------------------------------------------------------------------------
// Host port with two channels and a Wishbone register slave.
// ----------------------------------------------------------------------------
module hpc_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Links
  hpc_link_if.host link_a,
  hpc_link_if.host link_b
);

  hpc_pkg::hpc_word_t iface_a_output_word;
  hpc_pkg::hpc_word_t iface_b_output_word;
  hpc_pkg::hpc_word_t shared_control_word;
  hpc_pkg::hpc_word_t iface_a_input_word;
  hpc_pkg::hpc_word_t iface_b_input_word;
  hpc_pkg::hpc_word_t channel_response_status;
  logic [1:0] resp;
  logic [1:0] perr;
  logic [1:0] intr;
  logic wr_cycle;
  logic [15:0] wmask;
  logic [15:0] next_out_a;
  logic [15:0] next_out_b;
  logic [15:0] next_ctrl;
  logic [31:0] next_rdata;

  assign wr_cycle = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign next_out_a = (iface_a_output_word & ~wmask) | (wb_dat_i[15:0] & wmask);
  assign next_out_b = (iface_b_output_word & ~wmask) | (wb_dat_i[15:0] & wmask);
  assign next_ctrl = (shared_control_word & ~wmask) | (wb_dat_i[15:0] & wmask);
  assign channel_response_status = {10'h000, intr, perr, resp};

  // --------------------------------------------------------------------------
  // Writable registers.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      iface_a_output_word <= `HPC_RST_WORD;
      iface_b_output_word <= `HPC_RST_WORD;
      shared_control_word <= `HPC_RST_WORD;
    end else if (wr_cycle) begin
      if (wb_adr_i == `HPC_OFS_A_OUT) begin
        iface_a_output_word <= next_out_a;
      end
      if (wb_adr_i == `HPC_OFS_B_OUT) begin
        iface_b_output_word <= next_out_b;
      end
      if (wb_adr_i == `HPC_OFS_CTRL) begin
        shared_control_word <= next_ctrl;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data and acknowledge.
  // --------------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `HPC_OFS_A_OUT: next_rdata = {16'h0000, iface_a_output_word};
      `HPC_OFS_B_OUT: next_rdata = {16'h0000, iface_b_output_word};
      `HPC_OFS_CTRL: next_rdata = {16'h0000, shared_control_word};
      `HPC_OFS_A_IN: next_rdata = {16'h0000, iface_a_input_word};
      `HPC_OFS_B_IN: next_rdata = {16'h0000, iface_b_input_word};
      `HPC_OFS_STAT: next_rdata = {16'h0000, channel_response_status};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Channels A and B.
  // --------------------------------------------------------------------------
  hpc_host_chan u_chan_a (
    .mclk(mclk),
    .rst(rst),
    .out_word(iface_a_output_word),
    .sel_status(shared_control_word[`HPC_CW_SEL]),
    .nbcd(shared_control_word[`HPC_CW_NBCD]),
    .test(shared_control_word[`HPC_CW_TEST]),
    .wmark(shared_control_word[`HPC_CW_WMARK]),
    .noasm(shared_control_word[`HPC_CW_NOASM]),
    .mclr(shared_control_word[`HPC_CW_MCLR]),
    .wr(shared_control_word[`HPC_CW_WRITE]),
    .rd(shared_control_word[`HPC_CW_READ]),
    .in_word(iface_a_input_word),
    .resp(resp[0]),
    .perr(perr[0]),
    .intr(intr[0]),
    .link(link_a)
  );

  hpc_host_chan u_chan_b (
    .mclk(mclk),
    .rst(rst),
    .out_word(iface_b_output_word),
    .sel_status(shared_control_word[`HPC_CW_SEL + 1]),
    .nbcd(shared_control_word[`HPC_CW_NBCD + 1]),
    .test(shared_control_word[`HPC_CW_TEST + 1]),
    .wmark(shared_control_word[`HPC_CW_WMARK + 1]),
    .noasm(shared_control_word[`HPC_CW_NOASM + 1]),
    .mclr(shared_control_word[`HPC_CW_MCLR + 1]),
    .wr(shared_control_word[`HPC_CW_WRITE + 1]),
    .rd(shared_control_word[`HPC_CW_READ + 1]),
    .in_word(iface_b_input_word),
    .resp(resp[1]),
    .perr(perr[1]),
    .intr(intr[1]),
    .link(link_b)
  );

endmodule // hpc_host

// *** verilog/hpc_periph.sv ***
`timescale 1ns/1ps
`include "hpc_cfg.svh"

// ----------------------------------------------------------------------------
// Peripheral controller end of one channel.
// ----------------------------------------------------------------------------
module hpc_periph #(
  parameter logic [11:0] CONN_CODE = 12'h001,
  parameter logic [11:0] BAD_FUNC = 12'hfff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link
  hpc_link_if.periph link,
  // User side
  input wire logic [11:0] dev_status,
  input wire logic irq_req,
  input wire logic [11:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_last,
  output logic rd_take,
  output logic [11:0] wr_data,
  output logic wr_valid,
  output logic [11:0] func_code,
  output logic func_valid,
  output logic connected
);

  if (CONN_CODE == BAD_FUNC) begin : g_bad_codes
    $error("hpc_periph: connect code equals the rejected function code");
  end

  hpc_pkg::hpc_pstate_e state;
  logic req;
  logic par_ok;

  assign req = link.conn | link.func | link.dsig;
  assign par_ok = ^{link.out_code, link.out_par};

  // --------------------------------------------------------------------------
  // Status word and interrupt, registered towards the host.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.status <= `HPC_RST_CODE;
      link.intr <= 1'b0;
    end else begin
      link.status <= dev_status;
      link.intr <= irq_req;
    end
  end

  // --------------------------------------------------------------------------
  // Request handshake.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= hpc_pkg::HPC_IDLE;
      connected <= 1'b0;
      link.reply <= 1'b0;
      link.reject <= 1'b0;
      link.eor <= 1'b0;
      link.in_data <= `HPC_RST_CODE;
      link.in_par <= 1'b0;
      rd_take <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= `HPC_RST_CODE;
      func_valid <= 1'b0;
      func_code <= `HPC_RST_CODE;
    end else begin
      rd_take <= 1'b0;
      wr_valid <= 1'b0;
      func_valid <= 1'b0;
      if (link.mclr) begin
        state <= hpc_pkg::HPC_IDLE;
        connected <= 1'b0;
        link.reply <= 1'b0;
        link.reject <= 1'b0;
        link.eor <= 1'b0;
      end else if (!req) begin
        state <= hpc_pkg::HPC_IDLE;
        link.reply <= 1'b0;
        link.reject <= 1'b0;
        link.eor <= 1'b0;
      end else begin
        unique case (state)
          hpc_pkg::HPC_IDLE: begin
            if (link.conn) begin
              if (link.out_code == CONN_CODE && par_ok) begin
                connected <= 1'b1;
                link.reply <= 1'b1;
              end else begin
                connected <= 1'b0;
              end
              state <= hpc_pkg::HPC_ANSWERED;
            end else if (!connected) begin
              state <= hpc_pkg::HPC_ANSWERED;
            end else if (link.func) begin
              if (!par_ok) begin
                link.reject <= 1'b0;
              end else if (link.out_code == BAD_FUNC) begin
                link.reject <= 1'b1;
              end else begin
                link.reply <= 1'b1;
                func_code <= link.out_code;
                func_valid <= 1'b1;
              end
              state <= hpc_pkg::HPC_ANSWERED;
            end else if (link.wr) begin
              if (par_ok) begin
                link.reply <= 1'b1;
                wr_data <= link.out_code;
                wr_valid <= 1'b1;
              end
              state <= hpc_pkg::HPC_ANSWERED;
            end else if (link.rd) begin
              state <= hpc_pkg::HPC_WAIT_DATA;
            end else begin
              state <= hpc_pkg::HPC_ANSWERED;
            end
          end
          hpc_pkg::HPC_WAIT_DATA: begin
            if (rd_valid) begin
              link.in_data <= rd_data;
              link.in_par <= ~^rd_data;
              link.reply <= ~rd_last;
              link.eor <= rd_last;
              rd_take <= 1'b1;
              state <= hpc_pkg::HPC_ANSWERED;
            end
          end
          hpc_pkg::HPC_ANSWERED: begin
            state <= hpc_pkg::HPC_ANSWERED;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output parity error, held until master clear.
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.par_err <= 1'b0;
    end else if (state == hpc_pkg::HPC_IDLE && connected && !par_ok
                 && (link.func || (link.dsig && link.wr)) && !link.mclr) begin
      link.par_err <= 1'b1;
    end else if (link.mclr) begin
      link.par_err <= 1'b0;
    end
  end

endmodule // hpc_periph

// *** verification/hpc_link_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Checker on the link between host channel A and its controller.
// ----------------------------------------------------------------------------
module hpc_link_props #(
  parameter logic [11:0] CONN_CODE = 12'h001
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host requests
  input wire hpc_pkg::hpc_byte_t out_code,
  input wire logic out_par,
  input wire logic conn,
  input wire logic func,
  input wire logic dsig,
  input wire logic rd,
  input wire logic mclr,
  // Controller answers
  input wire logic reply,
  input wire logic reject,
  input wire logic eor,
  input wire logic par_err
);
  logic req;
  assign req = conn | func | dsig;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  reply_hold_a: assert property (reply && req && !mclr |=> reply)
    else $error("reply dropped while request held");
  reply_drop_a: assert property (reply && !req |=> !reply)
    else $error("reply stayed after request dropped");
  reply_cause_a: assert property ($rose(reply) |-> $past(req))
    else $error("reply without request");
  eor_excl_a: assert property (!(eor && reply))
    else $error("end of record together with reply");
  eor_read_a: assert property ($rose(eor) |-> $past(dsig && rd))
    else $error("end of record outside read");
  reject_func_a: assert property ($rose(reject) |-> $past(func))
    else $error("reject without function");
  perr_hold_a: assert property (par_err && !mclr |=> par_err)
    else $error("parity error lost without clear");
  perr_clear_a: assert property ($fell(par_err) |-> $past(mclr))
    else $error("parity error cleared without master clear");
  perr_set_a: assert property ($rose(func) && out_par == ^out_code |-> ##[1:3] par_err)
    else $error("bad function parity not flagged");
  conn_bad_a: assert property ($rose(conn) && (out_code != CONN_CODE || out_par != ~^out_code)
    |-> (!reply) [*4])
    else $error("reply to wrong connect");
endmodule // hpc_link_props

// *** verification/tb_hpc_host.sv ***
`timescale 1ns/1ps
module tb_hpc_host;
  // --------------------------------------------------------------------------
  // Bench signals and instances.
  // --------------------------------------------------------------------------
  localparam logic [11:0] CC = 12'h001;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic ack;
  logic [31:0] rdat;
  logic [15:0] iw;
  logic [11:0] d;
  logic [11:0] dst[2];
  logic [11:0] rdd[2];
  logic [11:0] wrd[2];
  logic [11:0] fcd[2];
  logic irq[2];
  logic rdv[2];
  logic rdl[2];
  logic con[2];
  logic rdt[2];
  logic wrv[2];
  logic fcv[2];
  int pulses[2] = '{0, 0};
  int bad_count = 0;
  int checked = 0;
  hpc_link_if lk[2] ();
  always #12.5 mclk = ~mclk;
  hpc_host u_hpc_host (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
    .link_a(lk[0]), .link_b(lk[1])
  );
  for (genvar g = 0; g < 2; g++) begin : g_end
    hpc_periph #(.CONN_CODE(CC)) u_hpc_periph (
      .mclk(mclk), .rst(rst), .link(lk[g]), .dev_status(dst[g]), .irq_req(irq[g]),
      .rd_data(rdd[g]), .rd_valid(rdv[g]), .rd_last(rdl[g]), .rd_take(rdt[g]),
      .wr_data(wrd[g]), .wr_valid(wrv[g]), .func_code(fcd[g]), .func_valid(fcv[g]),
      .connected(con[g])
    );
    always @(posedge mclk) begin
      if (wrv[g] || fcv[g] || rdt[g]) begin
        pulses[g] <= pulses[g] + 1;
      end
    end
  end
  hpc_link_props #(.CONN_CODE(CC)) u_hpc_link_props (
    .mclk(mclk), .rst(rst), .out_code(lk[0].out_code), .out_par(lk[0].out_par),
    .conn(lk[0].conn), .func(lk[0].func), .dsig(lk[0].dsig), .rd(lk[0].rd),
    .mclr(lk[0].mclr), .reply(lk[0].reply), .reject(lk[0].reject), .eor(lk[0].eor),
    .par_err(lk[0].par_err)
  );
  // --------------------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do @(posedge mclk); while (ack !== 1'b1);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wcw(input logic [15:0] v);
    wb(1'b1, 8'h08, {16'h0, v});
  endtask
  function automatic logic [15:0] ow(input logic [11:0] x, input logic [2:0] k);
    return {x, ~^x, k};
  endfunction
  task automatic poll(input int c, input logic e);
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'h14, 32'h0);
      if (rdat[c] === e) break;
    end
    chk("response", rdat[c], e);
  endtask
  task automatic op(input int c, input logic [15:0] w, input logic e);
    wb(1'b1, 8'(4 * c), {16'h0, w});
    if (!e) repeat (10) @(posedge mclk);
    poll(c, e);
    wb(1'b0, 8'h0c + 8'(4 * c), 32'h0);
    iw = rdat[15:0];
  endtask
  task automatic drop(input int c);
    wb(1'b1, 8'(4 * c), 32'h0);
    poll(c, 1'b0);
  endtask
  task automatic run(input int c);
    logic [11:0] code;
    code = 12'($urandom % 32'hfff);
    op(c, ow(12'h123, 3'h1), 1'b0);
    drop(c);
    op(c, ow(CC + 12'h1, 3'h2), 1'b0);
    drop(c);
    op(c, ow(CC, 3'h2), 1'b1);
    chk("connect status", iw, {dst[c], 4'h4});
    chk("connected", con[c], 1'b1);
    drop(c);
    op(c, ow(code, 3'h1), 1'b1);
    chk("function reply", iw, {dst[c], 4'h4});
    drop(c);
    chk("function code", fcd[c], code);
    op(c, ow(12'hfff, 3'h1), 1'b1);
    chk("function reject", iw, {dst[c], 4'h2});
    drop(c);
    wcw(16'h1 << c);
    wb(1'b0, 8'h0c + 8'(4 * c), 32'h0);
    chk("status select", rdat, {16'h0, dst[c], 4'h0});
    wcw(16'h1000 << c);
    repeat (3) begin
      d = 12'($urandom);
      op(c, ow(d, 3'h4), 1'b1);
      drop(c);
      chk("write byte", wrd[c], d);
    end
    wcw(16'h4000 << c);
    for (int k = 0; k < 3; k++) begin
      d = 12'($urandom);
      @(posedge mclk);
      rdd[c] <= d;
      rdv[c] <= 1'b1;
      rdl[c] <= (k == 2);
      op(c, 16'h0004, 1'b1);
      chk("read byte", iw, {d, ~^d, (k == 2 ? 3'b001 : 3'b100)});
      rdv[c] <= 1'b0;
      drop(c);
    end
    wcw(16'h0010 << c);
    d = 12'($urandom);
    op(c, ow(d, 3'h4), 1'b1);
    chk("test loopback", iw, {d, ~^d, 3'b100});
    drop(c);
    wcw(16'h0);
    op(c, {12'h055, ^12'h055, 3'h1}, 1'b0);
    wb(1'b0, 8'h14, 32'h0);
    chk("parity error", rdat[2 + c], 1'b1);
    drop(c);
    @(posedge mclk);
    irq[c] <= 1'b1;
    repeat (2) @(posedge mclk);
    wb(1'b0, 8'h14, 32'h0);
    chk("interrupt", rdat[4 + c], 1'b1);
    irq[c] <= 1'b0;
    repeat (2) @(posedge mclk);
    wb(1'b0, 8'h14, 32'h0);
    chk("interrupt gone", rdat[4 + c], 1'b0);
    wcw(16'h0400 << c);
    wcw(16'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk("parity cleared", rdat[2 + c], 1'b0);
    chk("disconnected", con[c], 1'b0);
    op(c, ow(code, 3'h1), 1'b0);
    drop(c);
    chk("accepted pulses", pulses[c], 32'd7);
  endtask
  // --------------------------------------------------------------------------
  // Main sequence and watchdog.
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h18b6));
    for (int c = 0; c < 2; c++) begin
      dst[c] = 12'($urandom);
      rdd[c] = 12'h0;
      irq[c] = 1'b0;
      rdv[c] = 1'b0;
      rdl[c] = 1'b0;
    end
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a <= 24; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk("reset word", rdat, 32'h0);
    end
    wb(1'b1, 8'h14, 32'hffff);
    wb(1'b1, 8'h18, 32'hffff);
    wb(1'b0, 8'h14, 32'h0);
    chk("status read only", rdat, 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (int c = 0; c < 2; c++) run(c);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end
endmodule // tb_hpc_host
